// [src/reply_cfg_consts.vh]
// constants for the can reply-policy and configuration block
// assumes a 250 mhz core clock and a classic wishbone register port
`ifndef REPLY_CFG_CONSTS_VH
`define REPLY_CFG_CONSTS_VH

// register byte addresses
`define RC_ADDR_CTRL      8'h00
`define RC_ADDR_CFG       8'h04
`define RC_ADDR_STATUS    8'h08
`define RC_ADDR_MASK      8'h0c
`define RC_ADDR_COUNT     8'h10

// ctrl fields
`define RC_CTRL_ENABLE    0
`define RC_CTRL_STRICT    1
`define RC_CTRL_RST       2'h3

// cfg fields (read only, latched switches)
`define RC_CFG_PROTO_LSB  0
`define RC_CFG_RATE_LSB   8
`define RC_CFG_BATT       16
`define RC_CFG_MONITOR    17

// status / mask bits
`define RC_EV_REPLY       0
`define RC_EV_ERROR       1
`define RC_EV_CORRUPT     2
`define RC_EV_DROP        3
`define RC_EV_PARAM       4
`define RC_EV_W           5

// bitrate codes
`define RC_RATE_10K       3'h0
`define RC_RATE_20K       3'h1
`define RC_RATE_50K       3'h2
`define RC_RATE_RSVD      3'h3
`define RC_RATE_125K      3'h4
`define RC_RATE_250K      3'h5
`define RC_RATE_500K      3'h6
`define RC_RATE_1M        3'h7
`define RC_RATE_DEFAULT   3'h5

// bit time in ns at 10 kbps, the slowest rate
`define RC_BIT_NS_10K     100000
`define RC_CLK_NS         4

// protocol selection codes on switches 1..5
`define RC_PROTO_PUBLIC   5'h00
`define RC_PROTO_BATT_MIN 5'h01

// reply kinds
`define RC_KIND_NONE      2'h0
`define RC_KIND_ANSWER    2'h1
`define RC_KIND_ERROR     2'h2
`define RC_KIND_CORRUPT   2'h3

`endif

// [src/switch_latch.v]
// samples the configuration switches once after reset
// assumes switch pins are asynchronous and static in operation
`timescale 1ns/10ps
`include "reply_cfg_consts.vh"

module switch_latch
(
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [7:0] sw_i,
  output reg  [4:0] proto_o,
  output reg  [2:0] rate_o,
  output reg        valid_o
);

  reg  [7:0] meta_q;
  reg  [7:0] sync_q;
  reg  [1:0] wait_q;

  always @(posedge clk_i)
  begin
    meta_q <= sw_i;
    sync_q <= meta_q;
  end

  // sw[0..4] are switches 1..5, sw[5..7] are switches 6..8 (6 is msb)
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wait_q  <= 2'h0;
      valid_o <= 1'b0;
      proto_o <= `RC_PROTO_PUBLIC;
      rate_o  <= `RC_RATE_DEFAULT;                   // [R8]
    end
    else if (!valid_o)
    begin
      // let the synchroniser fill before the single capture
      if (wait_q != 2'h3)
        wait_q <= wait_q + 2'h1;
      else
      begin
        valid_o <= 1'b1;                             // [R11]
        proto_o <= sync_q[4:0];                      // [R5]
        rate_o  <= {sync_q[5], sync_q[6], sync_q[7]}; // [R5] [R7]
      end
    end
  end

endmodule // switch_latch

// [src/rate_decode.v]
// decodes the three-bit bitrate code into a bit-time prescale
// assumes a latched code; combinational
`timescale 1ns/10ps
`include "reply_cfg_consts.vh"

module rate_decode
(
  input  wire [2:0]  code_i,
  input  wire        selectable_i,
  output reg  [2:0]  code_o,
  output reg  [15:0] presc_o
);

  // clocks per bit for a rate in kbit/s; a 1 kbit/s bit is ten 10k bits long
  function [15:0] bit_clks;
    input [9:0]  kbps;
    reg   [31:0] clks;
    begin
      clks     = (`RC_BIT_NS_10K * 10) / (`RC_CLK_NS * kbps);
      bit_clks = clks[15:0];
    end
  endfunction

  always @*
  begin
    code_o = code_i;
    // fixed-rate profiles and the reserved code fall back to the default
    if (!selectable_i || code_i == `RC_RATE_RSVD)    // [R11]
      code_o = `RC_RATE_DEFAULT;                     // [R8]
    case (code_o)                                    // [R7]
      `RC_RATE_10K:  presc_o = bit_clks(10'd10);
      `RC_RATE_20K:  presc_o = bit_clks(10'd20);
      `RC_RATE_50K:  presc_o = bit_clks(10'd50);
      `RC_RATE_125K: presc_o = bit_clks(10'd125);
      `RC_RATE_250K: presc_o = bit_clks(10'd250);
      `RC_RATE_500K: presc_o = bit_clks(10'd500);
      `RC_RATE_1M:   presc_o = bit_clks(10'd1000);
      default:       presc_o = bit_clks(10'd250);
    endcase
  end

endmodule // rate_decode

// [src/can_reply_policy.v]
// reply policy and configuration for the external can side of the bridge
// assumes a can controller that reports each received frame as one pulse
// with its checks, and a wishbone master on the same clock
//
// Contract
// R1 - In strict mode every observed frame gets a reply, whatever it holds; the code drops a frame when both reply slots are full.
// R2 - In strict mode a frame that breaks the public host format gets an error reply.
// R3 - In strict mode a frame corrupted on the wire is reported in the reply, not dropped.
// R4 - In filtered mode only fully conforming frames get a reply and all else is silent.
// R5 - Protocol or battery profile comes from switches 1 to 5, bitrate from 6 to 8 where selectable.
// R6 - For battery profiles switch 4 on selects monitor-only, off selects active management.
// R7 - Switches 6,7,8 form a code: 000 10k, 001 20k, 010 50k, 100 125k, 101 250k, 110 500k, 111 1M.
// R8 - The default bitrate is 250 kbit/s.
// R9 - The external node runs at the bitrate set on the switches.
// R10 - A battery profile overwrites the system battery parameters with no user action.
// R11 - Switches are sampled once after reset and code 011 falls back to the default rate.
`timescale 1ns/10ps
`include "reply_cfg_consts.vh"

module can_reply_policy
(
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output wire        err_o,
  // configuration switches, on = 1
  input  wire [7:0]  sw_i,
  // received frame report from the can controller
  input  wire        rx_valid_i,
  input  wire        rx_conform_i,
  input  wire        rx_crc_ok_i,
  input  wire        rx_form_ok_i,
  // reply request to the can transmitter
  output reg         reply_valid_o,
  output reg  [1:0]  reply_kind_o,
  input  wire        reply_ready_i,
  // configuration outputs
  output wire [2:0]  rate_code_o,
  output wire [15:0] bit_presc_o,
  output wire [4:0]  proto_o,
  output wire        batt_mode_o,
  output wire        monitor_only_o,
  output reg         param_write_o,
  output wire        irq_o
);

  reg  [1:0]  ctrl_q;
  reg  [`RC_EV_W-1:0] status_q;
  reg  [`RC_EV_W-1:0] mask_q;
  reg  [15:0] count_q;
  reg         param_done_q;
  reg         held_q;
  reg  [1:0]  held_kind_q;
  reg         ev_reply;
  reg         ev_error;
  reg         ev_corrupt;
  reg         ev_drop;
  reg  [1:0]  kind_d;
  reg         want_d;
  reg  [31:0] rd_d;
  reg  [`RC_EV_W-1:0] ev_vec;
  reg  [`RC_EV_W-1:0] clr_vec;

  wire [4:0]  sw_proto;
  wire [2:0]  sw_rate;
  wire        sw_valid;
  wire        is_public;
  wire        strict;
  wire        bus_req;
  wire        wr_stb;
  wire        busy;
  wire        lost;

  switch_latch u_switch_latch
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .sw_i    (sw_i),
    .proto_o (sw_proto),
    .rate_o  (sw_rate),
    .valid_o (sw_valid)
  );

  // profile 0 is the public host protocol; others are battery profiles
  assign is_public      = (sw_proto == `RC_PROTO_PUBLIC);
  assign proto_o        = sw_proto;                  // [R5]
  assign batt_mode_o    = sw_valid & ~is_public;
  assign monitor_only_o = batt_mode_o & sw_proto[3]; // [R6]

  // public protocol and battery profiles both take the switch rate here
  rate_decode u_rate_decode
  (
    .code_i       (sw_rate),
    .selectable_i (sw_valid),
    .code_o       (rate_code_o),
    .presc_o      (bit_presc_o)
  );

  // ctrl strict bit picks strict or filtered policy
  assign strict = ctrl_q[`RC_CTRL_STRICT];
  assign busy   = reply_valid_o & ~reply_ready_i;
  assign lost   = busy & held_q;

  // reply decision for one received frame
  always @*
  begin
    want_d     = 1'b0;
    kind_d     = `RC_KIND_NONE;
    ev_reply   = 1'b0;
    ev_error   = 1'b0;
    ev_corrupt = 1'b0;
    ev_drop    = 1'b0;
    if (rx_valid_i && ctrl_q[`RC_CTRL_ENABLE] && sw_valid && is_public)
    begin
      if (strict)
      begin
        want_d = 1'b1;                               // [R1]
        if (!rx_crc_ok_i || !rx_form_ok_i)
          kind_d = `RC_KIND_CORRUPT;                 // [R3]
        else if (!rx_conform_i)
          kind_d = `RC_KIND_ERROR;                   // [R2]
        else
          kind_d = `RC_KIND_ANSWER;
      end
      else if (rx_crc_ok_i && rx_form_ok_i && rx_conform_i)
      begin
        want_d = 1'b1;                               // [R4]
        kind_d = `RC_KIND_ANSWER;
      end
      // only with the waiting and the held slot both full is a frame lost
      ev_drop    = want_d & lost;
      ev_reply   = want_d & ~lost;
      ev_error   = ~lost & (kind_d == `RC_KIND_ERROR);
      ev_corrupt = ~lost & (kind_d == `RC_KIND_CORRUPT);
    end
  end

  // reply request holds until the transmitter takes it; one more reply
  // waits behind it so back-to-back frames are still answered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reply_valid_o <= 1'b0;
      reply_kind_o  <= `RC_KIND_NONE;
      held_q        <= 1'b0;
      held_kind_q   <= `RC_KIND_NONE;
    end
    else if (!busy)
    begin
      if (held_q)
      begin
        reply_valid_o <= 1'b1;                       // [R1]
        reply_kind_o  <= held_kind_q;
        held_q        <= want_d;
        held_kind_q   <= kind_d;
      end
      else if (want_d)
      begin
        reply_valid_o <= 1'b1;                       // [R1] [R4]
        reply_kind_o  <= kind_d;
      end
      else
      begin
        reply_valid_o <= 1'b0;
        reply_kind_o  <= `RC_KIND_NONE;
      end
    end
    else if (want_d && !held_q)
    begin
      held_q      <= 1'b1;                           // [R1]
      held_kind_q <= kind_d;
    end
  end

  // one parameter push once the battery profile is known
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      param_done_q  <= 1'b0;
      param_write_o <= 1'b0;
    end
    else
    begin
      param_write_o <= 1'b0;
      if (batt_mode_o && !param_done_q)
      begin
        param_done_q  <= 1'b1;
        param_write_o <= 1'b1;                       // [R10]
      end
    end
  end

  // wishbone: ack one cycle after the request, dropped the cycle after
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_stb  = bus_req & we_i & sel_i[0];
  assign err_o   = 1'b0;

  always @*
  begin
    case (adr_i)
      `RC_ADDR_CTRL:   rd_d = {30'h0, ctrl_q};
      `RC_ADDR_CFG:    rd_d = {14'h0, monitor_only_o, batt_mode_o,
                               5'h0, rate_code_o, 3'h0, sw_proto};
      `RC_ADDR_STATUS: rd_d = {27'h0, status_q};
      `RC_ADDR_MASK:   rd_d = {27'h0, mask_q};
      `RC_ADDR_COUNT:  rd_d = {16'h0, count_q};
      default:         rd_d = 32'h0;
    endcase
  end

  always @*
  begin
    ev_vec = {`RC_EV_W{1'b0}};
    ev_vec[`RC_EV_REPLY]   = ev_reply;
    ev_vec[`RC_EV_ERROR]   = ev_error;
    ev_vec[`RC_EV_CORRUPT] = ev_corrupt;
    ev_vec[`RC_EV_DROP]    = ev_drop;
    ev_vec[`RC_EV_PARAM]   = param_write_o;
    clr_vec = {`RC_EV_W{1'b0}};
    if (wr_stb && adr_i == `RC_ADDR_STATUS)
      clr_vec = dat_i[`RC_EV_W-1:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o    <= 1'b0;
      dat_o    <= 32'h0;
      ctrl_q   <= `RC_CTRL_RST;
      mask_q   <= {`RC_EV_W{1'b0}};
      status_q <= {`RC_EV_W{1'b0}};
      count_q  <= 16'h0;
    end
    else
    begin
      ack_o <= bus_req;
      if (bus_req && !we_i)
        dat_o <= rd_d;
      if (wr_stb && adr_i == `RC_ADDR_CTRL)
        ctrl_q <= dat_i[1:0];
      if (wr_stb && adr_i == `RC_ADDR_MASK)
        mask_q <= dat_i[`RC_EV_W-1:0];
      // set wins over a clear in the same cycle
      status_q <= (status_q & ~clr_vec) | ev_vec;
      if (wr_stb && adr_i == `RC_ADDR_COUNT)
        count_q <= 16'h0;
      else if (ev_reply)
        count_q <= count_q + 16'h1;
    end
  end

  assign irq_o = |(status_q & mask_q);

endmodule // can_reply_policy

// [dv/can_reply_policy_assertions.sv]
// concurrent checks on the reply-policy block, seen from its ports only
// assumes one clock with a synchronous active-high reset; bound below
`timescale 1ns/10ps
module can_reply_policy_assertions
(
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire        ack_o,
  input wire        rx_valid_i,
  input wire        rx_conform_i,
  input wire        rx_crc_ok_i,
  input wire        rx_form_ok_i,
  input wire        reply_valid_o,
  input wire [1:0]  reply_kind_o,
  input wire        reply_ready_i,
  input wire [2:0]  rate_code_o,
  input wire [4:0]  proto_o,
  input wire        batt_mode_o,
  input wire        monitor_only_o,
  input wire        param_write_o
);
  reg  [3:0] age_q;
  reg  [1:0] ctrl_q;
  reg  [1:0] pw_q;
  // switches are latched well before age 15
  wire       live = (age_q == 4'hf);
  wire       take = live && rx_valid_i && !reply_valid_o && (proto_o == 5'h00);
  wire       good = rx_crc_ok_i && rx_form_ok_i;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      age_q  <= 4'h0;
      ctrl_q <= 2'h3;
      pw_q   <= 2'h0;
    end
    else
    begin
      if (!live)
        age_q <= age_q + 4'h1;
      if (cyc_i && stb_i && we_i && ack_o && adr_i == 8'h00 && sel_i[0])
        ctrl_q <= dat_i[1:0];
      if (param_write_o && pw_q != 2'h3)
        pw_q <= pw_q + 2'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus request not answered in one cycle");
  strict_reply_a: assert property (take && ctrl_q == 2'h3 && good && rx_conform_i
    |=> reply_valid_o && reply_kind_o == 2'h1)
    else $error("strict frame not answered");
  error_kind_a: assert property (take && ctrl_q == 2'h3 && good && !rx_conform_i
    |=> reply_valid_o && reply_kind_o == 2'h2)
    else $error("nonconforming frame without error reply");
  corrupt_kind_a: assert property (take && ctrl_q == 2'h3 && !good |=> reply_valid_o && reply_kind_o == 2'h3)
    else $error("corrupt frame not reported");
  filt_silent_a: assert property (take && ctrl_q == 2'h1 && !(good && rx_conform_i) |=> !reply_valid_o)
    else $error("filtered mode answered a bad frame");
  reply_hold_a: assert property (reply_valid_o && !reply_ready_i |=> reply_valid_o && $stable(reply_kind_o))
    else $error("reply dropped before accepted");
  default_rate_a: assert property ($past(rst_i) |-> rate_code_o == 3'h5)
    else $error("rate not default out of reset");
  cfg_stable_a: assert property (live |-> $stable(rate_code_o) && $stable(proto_o))
    else $error("configuration changed after latch");
  batt_mode_a: assert property (live |-> batt_mode_o == (proto_o != 5'h00))
    else $error("battery mode wrong for profile");
  monitor_mode_a: assert property (live |-> monitor_only_o == (batt_mode_o && proto_o[3]))
    else $error("monitor mode wrong for switch 4");
  param_once_a: assert property (pw_q < 2'h2)
    else $error("parameter write more than once");
endmodule // can_reply_policy_assertions

bind can_reply_policy can_reply_policy_assertions u_chk
(
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .rx_valid_i, .rx_conform_i,
  .rx_crc_ok_i, .rx_form_ok_i, .reply_valid_o, .reply_kind_o, .reply_ready_i, .rate_code_o, .proto_o,
  .batt_mode_o, .monitor_only_o, .param_write_o
);

// [dv/frame_peer.sv]
// far side model: frame reports of the can controller and the reply taker
// assumes send is called just after a rising edge
`timescale 1ns/10ps
module frame_peer
(
  input  wire       clk_i,
  input  wire       stall_i,
  output reg        rx_valid_o,
  output reg        rx_conform_o,
  output reg        rx_crc_ok_o,
  output reg        rx_form_ok_o,
  input  wire       reply_valid_i,
  input  wire [1:0] reply_kind_i,
  output wire       reply_ready_o,
  output reg  [1:0] got_kind_o,
  output reg  [7:0] got_cnt_o
);
  initial
  begin
    rx_valid_o = 1'b0;
    {rx_conform_o, rx_crc_ok_o, rx_form_ok_o} = 3'h2;
    got_kind_o = 2'h0;
    got_cnt_o = 8'h00;
  end
  // slow taker: ready stays low while the bench stalls
  assign reply_ready_o = !stall_i;
  task send(input [2:0] q);
  begin
    rx_valid_o <= 1'b1;
    {rx_conform_o, rx_crc_ok_o, rx_form_ok_o} <= q;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    // qualifiers mean nothing between reports, so show the inverse
    {rx_conform_o, rx_crc_ok_o, rx_form_ok_o} <= ~q;
  end
  endtask
  always @(posedge clk_i)
    if (reply_valid_i && reply_ready_o)
    begin
      got_kind_o <= reply_kind_i;
      got_cnt_o  <= got_cnt_o + 8'h01;
    end
endmodule // frame_peer

// [dv/can_reply_policy_test.sv]
// self-checking bench for the reply-policy block
// drives the register port and switches; frames come from frame_peer
`timescale 1ns/10ps
`include "reply_cfg_consts.vh"
module can_reply_policy_test;
  reg         clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, stall = 1'b0;
  reg  [7:0]  adr_i = 8'h00, sw_i = 8'ha0, base;
  reg  [3:0]  sel_i = 4'hf;
  reg  [31:0] dat_i = 32'h0, rd;
  wire [31:0] dat_o;
  wire [15:0] bit_presc_o;
  wire [7:0]  got_cnt;
  wire [4:0]  proto_o;
  wire [2:0]  rate_code_o;
  wire [1:0]  reply_kind_o, got_kind;
  wire        ack_o, err_o, rx_valid_i, rx_conform_i, rx_crc_ok_i, rx_form_ok_i, reply_valid_o;
  wire        reply_ready_i, batt_mode_o, monitor_only_o, param_write_o, irq_o;
  // rows {strict, conform, crc ok, form ok, replied, kind}, row 0 lowest
  reg  [55:0] tbl = {7'b0101000, 7'b0011000, 7'b0111101, 7'b1000111,
                     7'b1110111, 7'b1101111, 7'b1011110, 7'b1111101};
  // clocks per bit at 4 ns for codes 7 down to 0; reserved code 3 runs at 250k
  reg  [127:0] presc_exp = {16'd250, 16'd500, 16'd1000, 16'd2000,
                            16'd1000, 16'd5000, 16'd12500, 16'd25000};
  reg  [6:0]  row;
  integer     err_count = 0, cmp_count = 0, pw_cnt = 0, pw0, i;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (param_write_o) pw_cnt <= pw_cnt + 1;
  can_reply_policy u_dut
  (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .sw_i,
    .rx_valid_i, .rx_conform_i, .rx_crc_ok_i, .rx_form_ok_i, .reply_valid_o, .reply_kind_o, .reply_ready_i,
    .rate_code_o, .bit_presc_o, .proto_o, .batt_mode_o, .monitor_only_o, .param_write_o, .irq_o
  );
  frame_peer u_peer
  (
    .clk_i, .stall_i(stall), .rx_valid_o(rx_valid_i), .rx_conform_o(rx_conform_i), .rx_crc_ok_o(rx_crc_ok_i),
    .rx_form_ok_o(rx_form_ok_i), .reply_valid_i(reply_valid_o), .reply_kind_i(reply_kind_o),
    .reply_ready_o(reply_ready_i), .got_kind_o(got_kind), .got_cnt_o(got_cnt)
  );
  task check(input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // classic cycle: hold until ack is sampled, then one idle cycle
  task wb(input w, input [7:0] a, input [31:0] d);
  begin
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  end
  endtask
  task do_reset(input [7:0] s);
  begin
    sw_i  <= s;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
  end
  endtask
  task frame(input [2:0] q, input rep, input [1:0] kind);
  begin
    base = got_cnt;
    // the far node runs at 250k, so the switches must select that rate
    check(rate_code_o, 3'h5);
    u_peer.send(q);
    repeat (3) @(posedge clk_i);
    check(got_cnt - base, rep);
    if (rep) check(got_kind, kind);
  end
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_count = err_count + 1;
    give_verdict;
  end
  initial
  begin
    do_reset(8'ha0);
    wb(1'b0, `RC_ADDR_CTRL, 32'h0);
    check(rd, 32'h3);
    wb(1'b0, `RC_ADDR_CFG, 32'h0);
    check(rd, 32'h500);
    wb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check(err_o, 1'b0);
    for (i = 0; i < 8; i = i + 1)
    begin
      row = tbl[i*7 +: 7];
      wb(1'b1, `RC_ADDR_CTRL, {30'h0, row[6], 1'b1});
      frame(row[5:3], row[2], row[1:0]);
    end
    wb(1'b0, `RC_ADDR_STATUS, 32'h0);
    check(rd, 32'h7);
    wb(1'b1, `RC_ADDR_MASK, 32'h2);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b1);
    wb(1'b1, `RC_ADDR_STATUS, 32'h2);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    // three frames while the taker stalls: one waits, one is held, one is lost
    wb(1'b1, `RC_ADDR_CTRL, 32'h3);
    base = got_cnt;
    stall <= 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      u_peer.send(3'h7);
      @(posedge clk_i);
    end
    stall <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(got_cnt - base, 2);
    wb(1'b0, `RC_ADDR_STATUS, 32'h0);
    check(rd, 32'hd);
    for (i = 0; i < 8; i = i + 1)
    begin
      do_reset({i[0], i[1], i[2], 5'h00});
      check(rate_code_o, (i == 3) ? 3'h5 : i[2:0]);
      check(bit_presc_o, presc_exp[i*16 +: 16]);
    end
    sw_i <= 8'h00;
    repeat (10) @(posedge clk_i);
    check(rate_code_o, 3'h7);
    for (i = 0; i < 2; i = i + 1)
    begin
      pw0 = pw_cnt;
      do_reset(i ? 8'ha9 : 8'ha1);
      check(pw_cnt - pw0, 1);
      check({batt_mode_o, monitor_only_o}, {1'b1, i[0]});
      check(proto_o, i ? 5'h09 : 5'h01);
      frame(3'h7, 1'b0, 2'h0);
    end
    give_verdict;
  end
endmodule // can_reply_policy_test
